//--- logic/fault_ctl_consts.svh
`ifndef FAULT_CTL_CONSTS_SVH
`define FAULT_CTL_CONSTS_SVH

// Clock
`define CLK_PERIOD_NS      40
// Blanking after turn-off, least time
`define BLANK_TIME_NS      1000
`define BLANK_CYCLES       ((`BLANK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Least comparator high time to validate an event
`define VALID_TIME_NS      600
`define VALID_CYCLES       ((`VALID_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Consecutive switching cycles before latching
`define PROT_EVENT_COUNT   3'h4
// Supply overvoltage persistence
`define SUPPLY_HI_TIME_US  20
`define SUPPLY_HI_CYCLES   ((`SUPPLY_HI_TIME_US * 1000) / `CLK_PERIOD_NS)
// Fault timer tick, a quarter millisecond
`define TIMER_TICK_US      250
`define TIMER_TICK_CYCLES  ((`TIMER_TICK_US * 1000) / `CLK_PERIOD_NS)
`define DEFAULT_TIMER_MS   10'h0C8
`define OVERLOAD_STEP      12'h001
`define SHORT_STEP         12'h004
// Feedback codes, 20 mV per step
`define FB_SKIP            8'h14
`define FB_FREEZE          8'h32
`define FB_FOLD_END        8'h4B
`define FB_CLAMP           8'hA0
`define FB_SHORT           8'hC8
// Peak setpoint, 20 mV per step on the sense threshold
`define PEAK_MAX           8'h28
`define PEAK_FLOOR         8'h0C
// Frequency setpoint in kHz and slopes (mul, shift)
`define FREQ_MIN           8'h1A
`define FREQ_NOM           8'h41
`define FREQ_MAX           8'h82
`define FOLD_MUL           8'hC8
`define FOLD_SHIFT         3'h7
`define EXC_MUL            8'h0D
`define EXC_SHIFT          3'h3
// Register offsets and fields
`define REG_CONTROL        12'h000
`define REG_STATUS         12'h004
`define REG_PROGRESS       12'h008
`define CTRL_LATCH_BIT     0
`define CTRL_RESET         1'h0

`endif

//--- logic/fault_ctl_pkg.sv
package fault_ctl_pkg;

   // Fault reaction states, Gray along run -> hiccup -> latched
   typedef enum logic [1:0] {
      ST_RUN     = 2'h0,
      ST_HICCUP  = 2'h1,
      ST_LATCHED = 2'h3
   } fault_state_type;

   // Operating point handed to the modulator
   typedef struct packed {
      logic       skip;
      logic [7:0] peak;
      logic [7:0] freq;
   } setpoint_type;

   // Status word as seen by software
   typedef struct packed {
      logic skip;
      logic short_circuit;
      logic overload;
      logic hiccup;
      logic fault_latched;
      logic supply_lockout;
      logic overvoltage;
   } status_type;

endpackage

//--- logic/sync_filter.sv
`timescale 1ns/100ps
// Three-stage synchroniser; output rises once stages two and three are both high, falls once they differ
module sync_filter #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // Asynchronous in, filtered out
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   logic [W-1:0] stage1;
   logic [W-1:0] stage2;
   logic [W-1:0] stage3;

   // Shift chain; stage1 feeds stage2 only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
      end else begin
         stage1 <= async_in;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // Agreement filter, clears while stages differ, holds while both are low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_out <= '0;
      end else begin
         sync_out <= (stage2 & stage3) | (sync_out & ~(stage2 ^ stage3));
      end
   end

endmodule

//--- logic/fault_timer_latch_control.sv
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`include "fault_ctl_consts.svh"
// Overview of operation
// - Latch off after four consecutive off-time protection pin events.
// - Protection latch-off holds until supply is cycled (power-up reset).
// - Ignore protection comparator for 1 us after each turn-off.
// - Count an event only if comparator stays high 600 ns or more.
// - Supply overvoltage longer than 20 us stops pulses, enters lockout.
// - Lockout clears only on supply cycling or line undervoltage recovery.
// - Feedback near 400 mV selects skip-cycle mode.
// - Feedback below 1 V holds peak setpoint at 31 percent; the code holds PEAK_FLOOR, 12 of 40, 30 percent.
// - Above 1 V the peak setpoint is feedback divided by four.
// - Frequency rises linearly 26 to 65 kHz, reaching 65 at 1.5 V.
// - Frequency fixed up to 3.2 V, where peak current clamps at maximum.
// - From 3.2 V to 4 V frequency rises linearly 65 to 130 kHz.
// - Reaching maximum peak current flags overload and starts the timer.
// - Overload threshold equals four times (0.8 V minus offset).
// - Above 4 V the timer runs four times faster.
// - Timer progress kept across overload and short-circuit moves.
// - Timer resets at start-up and on leaving the fault regions.
// - On expiry pulses stop at once, then hiccup or latch per variant.
// - Timer duration from pin; open or grounded pin gives default.
module fault_timer_latch_control
   import fault_ctl_pkg::*;
#(
   parameter int TICK_CYCLES = `TIMER_TICK_CYCLES
) (
   // Clock and power-up reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Comparator results, asynchronous
   input  wire logic        prot_cmp,
   input  wire logic        supply_hi_cmp,
   input  wire logic        line_undervoltage,
   input  wire logic        timer_pin_open,
   input  wire logic        timer_pin_short,
   input  wire logic        supply_restart,
   // Digitised levels and driver state, same clock
   input  wire logic        driver_on,
   input  wire logic [7:0]  feedback_level,
   input  wire logic [7:0]  line_power_limit_input,
   input  wire logic [9:0]  timer_ms,
   // Protection and operating point
   output logic             drive_enable,
   output logic             overvoltage_latch,
   output logic             supply_lockout,
   output logic             overload_condition,
   output logic             short_circuit_condition,
   output fault_state_type  fault_state,
   output setpoint_type     setpoint
);

   localparam int TW = $clog2(TICK_CYCLES + 1);

   // Linear segment: base + (x * mul) >> sh
   function automatic logic [7:0] slope(input logic [7:0] x,
                                        input logic [7:0] mul,
                                        input logic [2:0] sh,
                                        input logic [7:0] base);
      logic [15:0] prod;
      prod  = 16'(x) * 16'(mul);
      slope = base + 8'(prod >> sh);
   endfunction

   logic            prot_s;
   logic            supply_hi_s;
   logic            uv_s;
   logic            topen_s;
   logic            tshort_s;
   logic            restart_s;
   logic            uv_q;
   logic            restart_q;
   logic            drv_q;
   logic [4:0]      blank_cnt;
   logic [3:0]      high_cnt;
   logic            event_seen;
   logic            event_now;
   logic [2:0]      event_cnt;
   logic [9:0]      supply_cnt;
   logic            supply_trip;
   logic            uv_recover;
   logic [7:0]      peak_limit;
   logic [9:0]      overload_threshold;
   logic            in_fault;
   logic [TW-1:0]   tick_cnt;
   logic            tick;
   logic [11:0]     progress;
   logic [11:0]     next_progress;
   logic [9:0]      duration_ms;
   logic            expire;
   logic            latch_variant;
   logic            access;
   logic            mapped;
   status_type      status;
   setpoint_type    next_setpoint;

   sync_filter #(.W(6)) u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in ({supply_restart, timer_pin_short, timer_pin_open,
                  line_undervoltage, supply_hi_cmp, prot_cmp}),
      .sync_out ({restart_s, tshort_s, topen_s,
                  uv_s, supply_hi_s, prot_s})
   );

   // Edge history for driver and filtered levels
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drv_q     <= 1'b0;
         uv_q      <= 1'b0;
         restart_q <= 1'b0;
      end else begin
         drv_q     <= driver_on;
         uv_q      <= uv_s;
         restart_q <= restart_s;
      end
   end

   assign uv_recover = uv_q & ~uv_s;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         blank_cnt <= 5'h00;
      end else if (drv_q && !driver_on) begin
         blank_cnt <= 5'(`BLANK_CYCLES);
      end else if (blank_cnt != 5'h00) begin
         blank_cnt <= blank_cnt - 5'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         high_cnt <= 4'h0;
      end else if (driver_on || blank_cnt != 5'h00 || !prot_s) begin
         high_cnt <= 4'h0;
      end else if (high_cnt != 4'(`VALID_CYCLES)) begin
         high_cnt <= high_cnt + 4'h1;
      end
   end

   assign event_now = (high_cnt == 4'(`VALID_CYCLES - 1)) && prot_s &&
                      !driver_on && blank_cnt == 5'h00;

   // One validated event per off time, judged at next turn-on
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         event_seen <= 1'b0;
      end else if (!drv_q && driver_on) begin
         event_seen <= 1'b0;
      end else if (event_now) begin
         event_seen <= 1'b1;
      end
   end

   // consecutive count clears on an event-free cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         event_cnt <= 3'h0;
      end else if (!drv_q && driver_on) begin
         if (event_seen && event_cnt != `PROT_EVENT_COUNT) begin
            event_cnt <= event_cnt + 3'h1;
         end else if (!event_seen) begin
            event_cnt <= 3'h0;
         end
      end
   end

   // latch on the fourth consecutive event
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overvoltage_latch <= 1'b0;
      end else if (event_cnt == `PROT_EVENT_COUNT) begin
         overvoltage_latch <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         supply_cnt <= 10'h000;
      end else if (!supply_hi_s) begin
         supply_cnt <= 10'h000;
      end else if (!supply_trip) begin
         supply_cnt <= supply_cnt + 10'h001;
      end
   end

   assign supply_trip = supply_hi_s &&
                        supply_cnt == 10'(`SUPPLY_HI_CYCLES);

   // lockout, set wins over recovery clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         supply_lockout <= 1'b0;
      end else if (supply_trip) begin
         supply_lockout <= 1'b1;
      end else if (uv_recover) begin
         supply_lockout <= 1'b0;
      end
   end

   // overload threshold shifted by the line offset
   always_comb begin
      if (line_power_limit_input >= `PEAK_MAX) begin
         peak_limit = 8'h00;
      end else begin
         peak_limit = `PEAK_MAX - line_power_limit_input;
      end
      overload_threshold = {peak_limit, 2'b00};
   end

   assign overload_condition = {2'b00, feedback_level} >= overload_threshold;
   assign short_circuit_condition = feedback_level > `FB_SHORT;
   assign in_fault = overload_condition | short_circuit_condition;

   // Operating point from the feedback level
   always_comb begin
      next_setpoint = '0;
      next_setpoint.skip = feedback_level <= `FB_SKIP;
      if (feedback_level < `FB_FREEZE) begin
         next_setpoint.peak = `PEAK_FLOOR;
      end else if ((feedback_level >> 2) >= peak_limit) begin
         next_setpoint.peak = peak_limit;
      end else begin
         next_setpoint.peak = feedback_level >> 2;
      end
      if (feedback_level < `FB_FREEZE) begin
         next_setpoint.freq = `FREQ_MIN;
      end else if (feedback_level < `FB_FOLD_END) begin
         next_setpoint.freq = slope(feedback_level - `FB_FREEZE,
                                    `FOLD_MUL, `FOLD_SHIFT, `FREQ_MIN);
      end else if (feedback_level < `FB_CLAMP) begin
         next_setpoint.freq = `FREQ_NOM;
      end else if (feedback_level <= `FB_SHORT) begin
         next_setpoint.freq = slope(feedback_level - `FB_CLAMP,
                                    `EXC_MUL, `EXC_SHIFT, `FREQ_NOM);
      end else begin
         next_setpoint.freq = `FREQ_MAX;
      end
   end

   // Registered operating point
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         setpoint <= '{skip: 1'b1, peak: `PEAK_FLOOR, freq: `FREQ_MIN};
      end else begin
         setpoint <= next_setpoint;
      end
   end

   // Quarter-millisecond tick, restarted on fault entry
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt <= '0;
      end else if (!in_fault || tick) begin
         tick_cnt <= '0;
      end else begin
         tick_cnt <= tick_cnt + TW'(1);
      end
   end

   assign tick = tick_cnt == TW'(TICK_CYCLES - 1);

   // duration from pin, default when open or grounded
   assign duration_ms = (topen_s || tshort_s || timer_ms == 10'h000) ?
                        `DEFAULT_TIMER_MS : timer_ms;

   // fast step in short circuit, slow in overload
   assign next_progress = progress + (short_circuit_condition ?
                          `SHORT_STEP : `OVERLOAD_STEP);

   assign expire = fault_state == ST_RUN && in_fault && tick &&
                   next_progress >= {duration_ms, 2'b00};

   // timer resets at start-up and outside fault regions
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         progress <= 12'h000;
      end else if (!in_fault || fault_state != ST_RUN || expire) begin
         progress <= 12'h000;
      end else if (tick) begin
         progress <= next_progress;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_state <= ST_RUN;
      end else begin
         case (fault_state)
            ST_RUN: begin
               if (expire) begin
                  fault_state <= latch_variant ? ST_LATCHED : ST_HICCUP;
               end
            end
            ST_HICCUP: begin
               if ((restart_s && !restart_q) || uv_recover) begin
                  fault_state <= ST_RUN;
               end
            end
            ST_LATCHED: begin
               fault_state <= ST_LATCHED;
            end
            default: begin
               fault_state <= ST_RUN;
            end
         endcase
      end
   end

   // pulses stop in the cycle of the fault
   assign drive_enable = fault_state == ST_RUN && !expire &&
                         !overvoltage_latch && !supply_lockout &&
                         !supply_trip && !uv_s;

   // APB decode, zero wait states
   assign access  = psel & penable;
   assign mapped  = paddr == `REG_CONTROL || paddr == `REG_STATUS ||
                    paddr == `REG_PROGRESS;
   assign pready  = 1'b1;
   assign pslverr = access & ~mapped;

   assign status = '{skip: setpoint.skip,
                     short_circuit: short_circuit_condition,
                     overload: overload_condition,
                     hiccup: fault_state == ST_HICCUP,
                     fault_latched: fault_state == ST_LATCHED,
                     supply_lockout: supply_lockout,
                     overvoltage: overvoltage_latch};

   // Control register write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latch_variant <= `CTRL_RESET;
      end else if (access && pwrite && paddr == `REG_CONTROL) begin
         latch_variant <= pwdata[`CTRL_LATCH_BIT];
      end
   end

   // Read data captured in the setup phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            `REG_CONTROL:  prdata <= {31'h0, latch_variant};
            `REG_STATUS:   prdata <= {25'h0, status};
            `REG_PROGRESS: prdata <= {20'h0, progress};
            default:       prdata <= 32'h0000_0000;
         endcase
      end
   end

endmodule

//--- tb/fault_ctl_properties.sv
`timescale 1ns/100ps
// Watches the fault controller ports for protection and timer slips
module fault_ctl_properties
   import fault_ctl_pkg::*;
(
   // Clock and reset
   input wire logic            pclk,
   input wire logic            presetn,
   // Register bus
   input wire logic            psel,
   input wire logic            penable,
   input wire logic            pwrite,
   input wire logic [11:0]     paddr,
   input wire logic [31:0]     pwdata,
   input wire logic [31:0]     prdata,
   input wire logic            pready,
   input wire logic            pslverr,
   // Comparators and levels
   input wire logic            prot_cmp,
   input wire logic            supply_hi_cmp,
   input wire logic            line_undervoltage,
   input wire logic            timer_pin_open,
   input wire logic            timer_pin_short,
   input wire logic            supply_restart,
   input wire logic            driver_on,
   input wire logic [7:0]      feedback_level,
   input wire logic [7:0]      line_power_limit_input,
   input wire logic [9:0]      timer_ms,
   // Protection and operating point
   input wire logic            drive_enable,
   input wire logic            overvoltage_latch,
   input wire logic            supply_lockout,
   input wire logic            overload_condition,
   input wire logic            short_circuit_condition,
   input wire fault_state_type fault_state,
   input wire setpoint_type    setpoint
);
   int hi_cnt;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Run length of the raw supply comparator
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         hi_cnt <= 0;
      else
         hi_cnt <= supply_hi_cmp ? hi_cnt + 1 : 0;
   end

   ovl_level_a : assert property (
      line_power_limit_input <= 8'h28 |-> overload_condition ==
      ({2'h0, feedback_level} >= 10'(4 * (8'h28 - line_power_limit_input))))
      else $error("overload level wrong");
   short_level_a : assert property (
      short_circuit_condition == (feedback_level > 8'hC8))
      else $error("short level wrong");
   latch_hold_a : assert property (
      overvoltage_latch |=> overvoltage_latch) else $error("latch dropped");
   latch_stop_a : assert property (
      overvoltage_latch |-> !drive_enable) else $error("latched but driving");
   lockout_stop_a : assert property (
      supply_lockout |-> !drive_enable) else $error("lockout but driving");
   lockout_wait_a : assert property (
      $rose(supply_lockout) |-> hi_cnt >= 500) else $error("lockout early");
   lockout_clear_a : assert property (
      $fell(supply_lockout) |-> !line_undervoltage)
      else $error("lockout cleared without recovery");
   fault_stop_a : assert property (
      fault_state != ST_RUN |-> !drive_enable) else $error("fault but driving");
   latched_hold_a : assert property (
      fault_state == ST_LATCHED |=> fault_state == ST_LATCHED)
      else $error("latched state left");
   run_hold_a : assert property (
      fault_state == ST_RUN && drive_enable |=> fault_state == ST_RUN)
      else $error("fault entered while driving");
   apb_err_a : assert property (
      psel && penable |-> pready &&
      pslverr == !(paddr inside {12'h000, 12'h004, 12'h008}))
      else $error("bus response wrong");
endmodule

bind fault_timer_latch_control fault_ctl_properties u_props (.*);

//--- tb/comparator_model.sv
`timescale 1ns/100ps
// Behavioural comparators on the protection and supply pins
module comparator_model (
   // Gate drive seen by the pins
   input  wire logic driver_on,
   // Pin conditions set by the bench
   input  wire logic prot_hi,
   input  int        start_ns,
   input  int        width_ns,
   input  wire logic supply_over,
   // Comparator outputs
   output logic      prot_cmp,
   output logic      supply_hi_cmp
);
   initial prot_cmp = 1'h0;

   // Pin plateau above threshold once in each off time, low in on time
   always begin
      @(negedge driver_on);
      if (prot_hi) begin
         #(start_ns) prot_cmp = 1'h1;
         #(width_ns) prot_cmp = 1'h0;
      end
   end

   // Supply comparator with a little propagation delay
   assign #7 supply_hi_cmp = supply_over;
endmodule

//--- tb/fault_timer_latch_control_tb_top.sv
`timescale 1ns/100ps
// Self-checking bench for the fault controller
module fault_timer_latch_control_tb_top;
   import fault_ctl_pkg::*;
   localparam int TICK = 4;
   logic            presetn = 1'h0, psel = 1'h0, penable = 1'h0;
   logic            pwrite = 1'h0, line_undervoltage = 1'h0;
   logic            timer_pin_open = 1'h0, timer_pin_short = 1'h0;
   logic            supply_restart = 1'h0, driver_on = 1'h1;
   logic            prot_hi = 1'h0, supply_over = 1'h0;
   logic [11:0]     paddr = 12'h000;
   logic [31:0]     pwdata = 32'h0;
   logic [7:0]      feedback_level = 8'h00, line_power_limit_input = 8'h00;
   logic [9:0]      timer_ms = 10'h3FF;
   logic            pclk, pready, pslverr, err, prot_cmp, supply_hi_cmp;
   logic            drive_enable, overvoltage_latch, supply_lockout;
   logic            overload_condition, short_circuit_condition;
   logic [31:0]     prdata, rd, sp, ex;
   logic [7:0]      fb, off;
   logic [7:0]      tbl [9] = '{8'h14, 8'h15, 8'h32, 8'h4B, 8'h80, 8'hA0,
                               8'hB4, 8'hC8, 8'hF0};
   int              st [3] = '{100, 1100, 1100};
   int              wd [3] = '{700, 400, 800};
   fault_state_type fault_state;
   setpoint_type    setpoint;
   int              start_ns, width_ns, mismatches, n_tests, cycles;

   fault_timer_latch_control #(.TICK_CYCLES(TICK)) DUT (.*);
   comparator_model PART (.*);

   // Bus clock
   initial begin
      pclk = 1'h0;
      forever #20 pclk = ~pclk;
   end

   // Hang guard
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         $display("[ERR] %0t run too long", $time);
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("mismatches %0d of %0d checks", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask

   task automatic chk_bit(input logic got, exp, input string what);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t %s: got %b exp %b", $time, what, got, exp);
      end
   endtask

   task automatic chk_val(input logic [31:0] got, exp, input string what);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
      end
   endtask

   // One bus transfer; data and error taken at the completing edge
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask

   // Expected operating point for a feedback code and offset
   function automatic setpoint_type exp_sp(input logic [7:0] f, o);
      logic [15:0] q;
      exp_sp.skip = (f <= 8'h14);
      exp_sp.peak = (f < 8'h32) ? 8'h0C : f >> 2;
      if (exp_sp.peak > 8'h28 - o)
         exp_sp.peak = 8'h28 - o;
      if (f < 8'h32)
         q = 16'h1A;
      else if (f < 8'h4B)
         q = 16'h1A + (((f - 8'h32) * 16'hC8) >> 7);
      else if (f <= 8'hA0)
         q = 16'h41;
      else if (f < 8'hC8)
         q = 16'h41 + (((f - 8'hA0) * 16'h0D) >> 3);
      else
         q = 16'h82;
      exp_sp.freq = q[7:0];
   endfunction

   // Hold a feedback code, then compare the fault state
   task automatic fault_run(input logic [7:0] f, input int n,
                            input fault_state_type s);
      feedback_level <= f;
      cyc(n);
      chk_val({30'h0, fault_state}, {30'h0, s}, "fault state");
   endtask

   task automatic leave();
      supply_restart <= 1'h1;
      fault_run(8'h40, 8, ST_RUN);
      supply_restart <= 1'h0;
      cyc(2);
   endtask

   // Switching cycle: 60-cycle off time with a pin plateau, then on time
   task automatic sw(input int s, w);
      start_ns = s;
      width_ns = w;
      driver_on <= 1'h0;
      cyc(60);
      driver_on <= 1'h1;
      cyc(10);
   endtask

   task automatic rst();
      presetn <= 1'h0;
      cyc(5);
      presetn <= 1'h1;
      cyc(1);
   endtask

   // Main sequence
   initial begin
      void'($urandom(30));
      rst();
      chk_val({15'h0, setpoint}, 32'h0001_0C1A, "reset point");
      chk_val({30'h0, fault_state}, 32'h0, "reset state");
      apb(1'h1, 12'h004, 32'h7F);
      apb(1'h0, 12'h004, 32'h0);
      chk_val(rd, 32'h40, "status");
      apb(1'h0, 12'h008, 32'h0);
      chk_val(rd, 32'h0, "progress");
      apb(1'h0, 12'h00C, 32'h0);
      chk_bit(err, 1'h1, "unmapped error");
      chk_val(rd, 32'h0, "unmapped data");
      // Operating point: corner codes, then random codes and offsets
      for (int i = 0; i < 109; i++) begin
         fb = (i < 9) ? tbl[i] : 8'($urandom);
         off = (i < 9) ? 8'h00 : 8'($urandom_range(20));
         feedback_level <= fb;
         line_power_limit_input <= off;
         cyc(4);
         sp = {15'h0, setpoint};
         ex = {15'h0, exp_sp(fb, off)};
         chk_val(sp, ex, "point");
      end
      line_power_limit_input <= 8'h00;
      timer_ms <= 10'h002;
      fault_run(8'h40, 4, ST_RUN);
      // Overload alone: eight ticks of four cycles to expiry
      fault_run(8'hB0, 24, ST_RUN);
      apb(1'h0, 12'h008, 32'h0);
      chk_bit(rd != 32'h0, 1'h1, "progress runs");
      fault_run(8'hB0, 16, ST_HICCUP);
      chk_bit(drive_enable, 1'h0, "pulses stop");
      leave();
      // Leaving the fault region clears progress
      fault_run(8'hB0, 20, ST_RUN);
      fault_run(8'h40, 4, ST_RUN);
      apb(1'h0, 12'h008, 32'h0);
      chk_val(rd, 32'h0, "progress clear");
      fault_run(8'hB0, 24, ST_RUN);
      // Short circuit runs four times faster, progress kept on moves
      fault_run(8'hD0, 6, ST_HICCUP);
      leave();
      feedback_level <= 8'hD0;
      cyc(5);
      fault_run(8'hB0, 20, ST_HICCUP);
      leave();
      // Open pin, grounded pin and zero duration fall back to default
      for (int k = 0; k < 3; k++) begin
         timer_pin_open <= (k == 0);
         timer_pin_short <= (k == 1);
         timer_ms <= (k == 2) ? 10'h000 : 10'h002;
         cyc(6);
         fault_run(8'hB0, 48, ST_RUN);
         fault_run(8'h40, 4, ST_RUN);
      end
      // Latch-off variant ignores restart
      timer_ms <= 10'h002;
      apb(1'h1, 12'h000, 32'h1);
      apb(1'h0, 12'h000, 32'h0);
      chk_val(rd, 32'h1, "control");
      fault_run(8'hD0, 16, ST_LATCHED);
      apb(1'h0, 12'h004, 32'h0);
      chk_val(rd, 32'h34, "status latched");
      supply_restart <= 1'h1;
      fault_run(8'h40, 10, ST_LATCHED);
      supply_restart <= 1'h0;
      rst();
      // Supply overvoltage shorter, then longer than the limit
      supply_over <= 1'h1;
      cyc(480);
      chk_bit(supply_lockout, 1'h0, "lockout early");
      supply_over <= 1'h0;
      cyc(10);
      supply_over <= 1'h1;
      cyc(520);
      chk_bit(supply_lockout, 1'h1, "lockout");
      chk_bit(drive_enable, 1'h0, "lockout stop");
      supply_over <= 1'h0;
      line_undervoltage <= 1'h1;
      cyc(20);
      chk_bit(supply_lockout, 1'h1, "lockout hold");
      line_undervoltage <= 1'h0;
      cyc(10);
      chk_bit(supply_lockout, 1'h0, "lockout clear");
      // Three events, then blanked, short or valid fourth event
      prot_hi <= 1'h1;
      for (int k = 0; k < 3; k++) begin
         for (int j = 0; j < 3; j++)
            sw(1100, 800);
         sw(st[k], wd[k]);
         chk_bit(overvoltage_latch, k == 2, "latch");
      end
      chk_bit(drive_enable, 1'h0, "latch stop");
      cyc(100);
      chk_bit(overvoltage_latch, 1'h1, "latch hold");
      rst();
      chk_bit(overvoltage_latch, 1'h0, "latch cleared");
      report_and_stop();
   end
endmodule
